/* File: iec_pkg.sv */
// How it works
// - Early transmit, early receive, link change, deferred transmit and pause enables are read/write at 31, 30, 29, 28 and 26.
// - With bit 16 set, pending early transmit and early receive events feed the normal summary.
// - With bit 15 set, pending pause, deferred transmit and link change events feed the abnormal summary.
// - Bits 14:0 of the second enable register read back the primary enable bits and ignore writes.
// - Bits 31:16 of the command register are loaded from the serial EEPROM word when it arrives.
// - Cold state support bit 31 is read/write and drives bit 31 of configuration register 48.
// - Wake polarity bit 27 gives a positive wake pulse at 0 and a negative one at 1.
// - Wake pin enable bit 26 turns the wake output off at 0 and on at 1.
// - Pad bit 25 picks the conventional pad only in card-bus mode and is ignored otherwise.
// - With sticky bit 24 at 0 power-up drops the wake signal; at 1 it stays asserted.
// - LED bit 23 picks the three-LED scheme at 0 and the four-LED scheme at 1.
// - Receive FIFO field 22:21 gives 2K for code 10 and 1K for code 11; 00 and 01 are reserved.
// - Each added status bit latches on its event (early transmit and early receive only while enabled) and clears only when software writes 1 to it.
// - Early receive status sets only while its enable is on and the first descriptor is filled.
`default_nettype none

package iec_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] OFS_SECOND_STATUS = 8'h80;
   localparam logic [7:0] OFS_IRQ_ENABLE_SECOND = 8'h84;
   localparam logic [7:0] OFS_COMMAND_CONFIG = 8'h88;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h90;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h94;
   localparam logic [31:0] RST_IRQ_ENABLE_SECOND = 32'h00000000;
   localparam logic [31:0] RST_COMMAND_CONFIG = 32'h00000000;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int BIT_EARLY_TX = 31;
   localparam int BIT_EARLY_RX = 30;
   localparam int BIT_LINK_CHANGE = 29;
   localparam int BIT_DEFERRED_TX = 28;
   localparam int BIT_PAUSE_RX = 26;
   localparam int BIT_NORMAL_MERGE = 16;
   localparam int BIT_ABNORMAL_MERGE = 15;
   localparam int BIT_COLD_SUPPORT = 31;
   localparam int BIT_WAKE_POLARITY = 27;
   localparam int BIT_WAKE_PIN_EN = 26;
   localparam int BIT_PAD_SEL = 25;
   localparam int BIT_WAKE_STICKY = 24;
   localparam int BIT_LED_SCHEME = 23;
   localparam int BIT_RXFIFO_LO = 21;
   localparam int PRIMARY_WIDTH = 15;
   localparam int EVENT_COUNT = 5;

   // Writable bits; everything else reads zero, except bits 14:0 of the second enable register, which read the primary enables
   localparam logic [31:0] MASK_IRQ_ENABLE_SECOND = 32'hF4018000;
   localparam logic [31:0] MASK_COMMAND_CONFIG = 32'h8FE00000;
   localparam logic [1:0] RXFIFO_2K = 2'h2;
   localparam logic [1:0] RXFIFO_1K = 2'h3;
endpackage : iec_pkg

`default_nettype wire

/* File: iec_sticky.sv */
`default_nettype none

module iec_sticky #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Set and clear
   input wire logic [W-1:0] set,
   input wire logic [W-1:0] clr,
   output logic [W-1:0] q
);
   // Set beats a clear in the same cycle so no event is lost
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
      end else begin
         q <= (q & ~clr) | set;
      end
   end
endmodule : iec_sticky

`default_nettype wire

/* File: iec_regs.sv */
`default_nettype none

module iec_regs (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Events, one-cycle pulses
   input wire logic ev_early_tx,
   input wire logic ev_early_rx,
   input wire logic rx_first_desc_filled,
   input wire logic ev_link_change,
   input wire logic ev_deferred_tx,
   input wire logic ev_pause_rx,
   // Primary enables and card mode
   input wire logic [iec_pkg::PRIMARY_WIDTH-1:0] primary_irq_enable,
   input wire logic cardbus_mode,
   // EEPROM recall
   input wire logic eeprom_load,
   input wire logic [15:0] eeprom_word,
   // Wake
   input wire logic wake_event,
   input wire logic power_up,
   output logic wake_pin_o,
   output logic wake_pin_oe,
   // Configuration outputs
   output logic config_reg_48_bit31,
   output logic conventional_pad,
   output logic led_four,
   output logic [1:0] rx_fifo_size,
   // Summaries and interrupt
   output logic normal_summary_add,
   output logic abnormal_summary_add,
   output logic irq
);
   import iec_pkg::*;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   logic [31:0] enable_second;
   logic [31:0] command_config;
   logic [4:0] irq_mask;
   logic [7:0] dp_addr;
   logic dp_write;
   wire addr_phase = hsel && hready && htrans[1];
   wire rd_take = addr_phase && !hwrite;
   wire wr_now = dp_write;
   wire wr_enable2 = wr_now && (dp_addr == OFS_IRQ_ENABLE_SECOND);
   wire wr_command = wr_now && (dp_addr == OFS_COMMAND_CONFIG);
   wire wr_status = wr_now && (dp_addr == OFS_SECOND_STATUS);
   wire wr_mask = wr_now && (dp_addr == OFS_IRQ_MASK);
   wire rd_irq_status = rd_take && (haddr[7:0] == OFS_IRQ_STATUS);

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         dp_addr <= 8'h00;
         dp_write <= 1'b0;
      end else begin
         dp_addr <= haddr[7:0];
         dp_write <= addr_phase && hwrite;
      end
   end

   // Zero wait states; word access only, hsize is not checked
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // ----------------------------------------
   // Event latching
   // ----------------------------------------
   wire [4:0] en5 = {enable_second[BIT_EARLY_TX], enable_second[BIT_EARLY_RX],
      enable_second[BIT_LINK_CHANGE], enable_second[BIT_DEFERRED_TX],
      enable_second[BIT_PAUSE_RX]};
   // Order: early tx, early rx, link change, deferred tx, pause
   wire [4:0] raw_ev = {ev_early_tx, ev_early_rx && rx_first_desc_filled, ev_link_change,
      ev_deferred_tx, ev_pause_rx};
   wire [4:0] ev_set = raw_ev & {en5[4:3], 3'b111};
   wire [31:0] w1c = wr_status ? hwdata : 32'h00000000;
   wire [4:0] ev_clr = {w1c[BIT_EARLY_TX], w1c[BIT_EARLY_RX], w1c[BIT_LINK_CHANGE],
      w1c[BIT_DEFERRED_TX], w1c[BIT_PAUSE_RX]};
   logic [4:0] ev_status;
   logic [1:0] sum_status;
   logic [4:0] irq_status;

   iec_sticky #(.W(EVENT_COUNT)) u_event_status (
      .mclk(mclk),
      .reset_n(reset_n),
      .set(ev_set),
      .clr(ev_clr),
      .q(ev_status)
   );

   // ----------------------------------------
   // Summaries
   // ----------------------------------------
   wire [4:0] pending = ev_status & en5;
   wire normal_hit = enable_second[BIT_NORMAL_MERGE] && (|pending[4:3]);
   wire abnormal_hit = enable_second[BIT_ABNORMAL_MERGE] && (|pending[2:0]);
   assign normal_summary_add = normal_hit;
   assign abnormal_summary_add = abnormal_hit;
   // Arm from next status, so clearing cause and summary together sticks
   wire [4:0] ev_next = (ev_status & ~ev_clr) | ev_set;
   wire [4:0] pending_next = ev_next & en5;
   wire normal_arm = enable_second[BIT_NORMAL_MERGE] && (|pending_next[4:3]);
   wire abnormal_arm = enable_second[BIT_ABNORMAL_MERGE] && (|pending_next[2:0]);

   iec_sticky #(.W(2)) u_summary_status (
      .mclk(mclk),
      .reset_n(reset_n),
      .set({normal_arm, abnormal_arm}),
      .clr({w1c[BIT_NORMAL_MERGE], w1c[BIT_ABNORMAL_MERGE]}),
      .q(sum_status)
   );

   // Interrupt copy clears on read so the w1c view stays undisturbed
   iec_sticky #(.W(EVENT_COUNT)) u_irq_status (
      .mclk(mclk),
      .reset_n(reset_n),
      .set(ev_set),
      .clr(rd_irq_status ? 5'h1F : 5'h00),
      .q(irq_status)
   );
   assign irq = |(irq_status & irq_mask);

   // ----------------------------------------
   // Enable and command registers
   // ----------------------------------------
   wire [31:0] eeprom_ext = {eeprom_word, 16'h0000};
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         enable_second <= RST_IRQ_ENABLE_SECOND;
         command_config <= RST_COMMAND_CONFIG;
         irq_mask <= 5'h00;
      end else begin
         if (wr_enable2) begin
            enable_second <= hwdata & MASK_IRQ_ENABLE_SECOND;
         end
         if (eeprom_load) begin
            command_config <= eeprom_ext & MASK_COMMAND_CONFIG;
         end else if (wr_command) begin
            command_config <= hwdata & MASK_COMMAND_CONFIG;
         end
         if (wr_mask) begin
            irq_mask <= hwdata[4:0];
         end
      end
   end

   // ----------------------------------------
   // Configuration outputs
   // ----------------------------------------
   assign config_reg_48_bit31 = command_config[BIT_COLD_SUPPORT];
   assign conventional_pad = cardbus_mode && command_config[BIT_PAD_SEL];
   assign led_four = command_config[BIT_LED_SCHEME];
   // Reserved codes pass through; software must not use them
   assign rx_fifo_size = command_config[BIT_RXFIFO_LO+1:BIT_RXFIFO_LO];

   // ----------------------------------------
   // Wake pin
   // ----------------------------------------
   logic wake_active;
   wire wake_drop = power_up && !command_config[BIT_WAKE_STICKY];
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wake_active <= 1'b0;
      end else if (wake_event) begin
         wake_active <= 1'b1;
      end else if (wake_drop) begin
         wake_active <= 1'b0;
      end
   end
   assign wake_pin_oe = command_config[BIT_WAKE_PIN_EN];
   assign wake_pin_o = wake_active ^ command_config[BIT_WAKE_POLARITY];

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   wire [31:0] rd_status = {ev_status[4:2], ev_status[1], 1'b0, ev_status[0], 9'h000,
      sum_status, primary_irq_enable};
   wire [31:0] rd_enable2 = {enable_second[31:15], primary_irq_enable};
   wire [7:0] ra = haddr[7:0];
   wire [31:0] rd_mux =
      (ra == OFS_SECOND_STATUS) ? rd_status :
      (ra == OFS_IRQ_ENABLE_SECOND) ? rd_enable2 :
      (ra == OFS_COMMAND_CONFIG) ? command_config :
      (ra == OFS_IRQ_STATUS) ? {27'h0000000, irq_status} :
      (ra == OFS_IRQ_MASK) ? {27'h0000000, irq_mask} : 32'h00000000;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         hrdata <= 32'h00000000;
      end else if (rd_take) begin
         hrdata <= rd_mux;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_enable_write;
      wr_enable2;
   endsequence
   sequence s_enable_holds;
      ##1 (enable_second[BIT_EARLY_TX] == $past(hwdata[BIT_EARLY_TX]));
   endsequence

   a_enable_write_sticks: assert property (@(posedge mclk) disable iff (!reset_n)
      s_enable_write |-> s_enable_holds) else $error("enable write not stored");
   a_normal_merge_gate: assert property (@(posedge mclk) disable iff (!reset_n)
      normal_summary_add |-> enable_second[BIT_NORMAL_MERGE] && (|ev_status[4:3]))
      else $error("normal summary without cause");
   a_abnormal_merge_on: assert property (@(posedge mclk) disable iff (!reset_n)
      (enable_second[BIT_ABNORMAL_MERGE] && (|pending[2:0])) |-> abnormal_summary_add)
      else $error("abnormal summary missing");
   a_mirror_primary: assert property (@(posedge mclk) disable iff (!reset_n)
      rd_take && (ra == OFS_IRQ_ENABLE_SECOND) |=> hrdata[14:0] == $past(primary_irq_enable))
      else $error("mirror mismatch");
   a_eeprom_recall: assert property (@(posedge mclk) disable iff (!reset_n)
      eeprom_load |=> command_config[31:16] == ($past(eeprom_word) & 16'h8FE0))
      else $error("eeprom recall wrong");
   a_sticky_status_holds: assert property (@(posedge mclk) disable iff (!reset_n)
      ev_status[4] && !ev_clr[4] |=> ev_status[4]) else $error("status lost");
   a_early_rx_gate: assert property (@(posedge mclk) disable iff (!reset_n)
      !ev_status[3] ##1 ev_status[3] |->
      $past(en5[3]) && $past(ev_early_rx) && $past(rx_first_desc_filled))
      else $error("early rx set without cause");
   a_wake_drop: assert property (@(posedge mclk) disable iff (!reset_n)
      wake_drop && !wake_event |=> !wake_active) else $error("wake not dropped");
   a_reserved_zero: assert property (@(posedge mclk) disable iff (!reset_n)
      command_config[30:28] == 3'h0 && enable_second[27] == 1'b0)
      else $error("reserved bit set");

   // ----------------------------------------
   // Checks on configuration and interrupt paths
   // ----------------------------------------
   a_cold_bit_maps: assert property (@(posedge mclk) disable iff (!reset_n)
      wr_command && !eeprom_load |=> config_reg_48_bit31 == $past(hwdata[BIT_COLD_SUPPORT]))
      else $error("cold support bit not mapped");
   a_wake_idle_level: assert property (@(posedge mclk) disable iff (!reset_n)
      !wake_active |-> wake_pin_o == command_config[BIT_WAKE_POLARITY])
      else $error("wake idle level wrong");
   a_wake_pulse_level: assert property (@(posedge mclk) disable iff (!reset_n)
      wake_active |-> wake_pin_o != command_config[BIT_WAKE_POLARITY])
      else $error("wake pulse level wrong");
   a_wake_pin_gate: assert property (@(posedge mclk) disable iff (!reset_n)
      !command_config[BIT_WAKE_PIN_EN] |-> !wake_pin_oe) else $error("wake pin driven while off");
   a_pad_no_effect: assert property (@(posedge mclk) disable iff (!reset_n)
      !cardbus_mode |-> !conventional_pad) else $error("pad select outside card mode");
   a_pad_select: assert property (@(posedge mclk) disable iff (!reset_n)
      cardbus_mode |-> conventional_pad == command_config[BIT_PAD_SEL])
      else $error("pad select not applied");
   a_led_scheme: assert property (@(posedge mclk) disable iff (!reset_n)
      wr_command && !eeprom_load |=> led_four == $past(hwdata[BIT_LED_SCHEME]))
      else $error("led scheme not stored");
   a_fifo_field: assert property (@(posedge mclk) disable iff (!reset_n)
      wr_command && !eeprom_load |=>
      rx_fifo_size == $past(hwdata[BIT_RXFIFO_LO+1:BIT_RXFIFO_LO]))
      else $error("fifo size not stored");
   a_status_w1c: assert property (@(posedge mclk) disable iff (!reset_n)
      wr_status && hwdata[BIT_EARLY_TX] && !ev_set[4] |=> !ev_status[4])
      else $error("status not cleared");
   a_summary_clear: assert property (@(posedge mclk) disable iff (!reset_n)
      wr_status && hwdata[BIT_NORMAL_MERGE] && hwdata[BIT_EARLY_TX] && hwdata[BIT_EARLY_RX]
      && !ev_set[4] && !ev_set[3] |=> !sum_status[1]) else $error("summary not cleared");
   a_abnormal_needs_enable: assert property (@(posedge mclk) disable iff (!reset_n)
      abnormal_summary_add |-> |(ev_status[2:0] & {enable_second[BIT_LINK_CHANGE],
      enable_second[BIT_DEFERRED_TX], enable_second[BIT_PAUSE_RX]}))
      else $error("abnormal summary without enabled event");
   a_normal_merge_off: assert property (@(posedge mclk) disable iff (!reset_n)
      !enable_second[BIT_NORMAL_MERGE] |-> !normal_summary_add)
      else $error("normal summary while merge off");
   a_abnormal_merge_off: assert property (@(posedge mclk) disable iff (!reset_n)
      !enable_second[BIT_ABNORMAL_MERGE] |-> !abnormal_summary_add)
      else $error("abnormal summary while merge off");
   a_mirror_status: assert property (@(posedge mclk) disable iff (!reset_n)
      rd_take && (ra == OFS_SECOND_STATUS) |=> hrdata[14:0] == $past(primary_irq_enable))
      else $error("status mirror mismatch");
   a_enable_reserved: assert property (@(posedge mclk) disable iff (!reset_n)
      (enable_second & ~MASK_IRQ_ENABLE_SECOND) == 32'h00000000)
      else $error("enable reserved bit set");
   a_command_reserved: assert property (@(posedge mclk) disable iff (!reset_n)
      (command_config & ~MASK_COMMAND_CONFIG) == 32'h00000000)
      else $error("command reserved bit set");
   a_irq_read_clear: assert property (@(posedge mclk) disable iff (!reset_n)
      rd_irq_status && !(|ev_set) |=> irq_status == 5'h00)
      else $error("irq status not cleared by read");
   a_irq_raise: assert property (@(posedge mclk) disable iff (!reset_n)
      (|(ev_set & irq_mask)) && !wr_mask |=> irq) else $error("irq not raised");
   a_wake_set: assert property (@(posedge mclk) disable iff (!reset_n)
      wake_event |=> wake_active) else $error("wake event lost");
   a_wake_sticky_keeps: assert property (@(posedge mclk) disable iff (!reset_n)
      wake_active && command_config[BIT_WAKE_STICKY] |=> wake_active)
      else $error("sticky wake dropped");
endmodule : iec_regs

`default_nettype wire

/* File: iec_host.sv */
`default_nettype none

module iec_host (
   // Clock and handshake
   input wire logic mclk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   // Request
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [31:0] hwdata
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
   end

   // Bounded, so a stuck slave ends the run
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (hready !== 1'b1 && n < 20);
      if (hready !== 1'b1) begin
         tb.mismatches++;
         tb.results();
      end
   endtask : wait_ready

   task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd,
      output logic [31:0] rd);
      @(posedge mclk);
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask : xfer
endmodule : iec_host

`default_nettype wire

/* File: tb.sv */
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import iec_pkg::*;

   // ----------------------------------------
   // Signals
   // ----------------------------------------
   typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e;} iec_row_s;
   logic mclk;
   logic reset_n = 1'b0;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans, rxfs;
   logic hwrite, hreadyout, hresp, rx_fill, card, wpo, wpoe, c48, pad, led4, nsum, asum, irq;
   logic [7:0] strobe = 8'h0;
   logic [14:0] prim = 15'h1234;
   logic [15:0] eword = 16'hFFFF;
   int mismatches = 0;
   int samples_checked = 0;
   iec_row_s rows [4] = '{
      '{8'h84, 32'hFFFFFFFF, 32'hF4019234},
      '{8'h84, 32'h00000000, 32'h00001234},
      '{8'h8C, 32'hFFFFFFFF, 32'h00000000},
      '{8'h94, 32'hFFFFFFFF, 32'h0000001F}};

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   iec_host host (.mclk(mclk), .hready(hreadyout), .hrdata(hrdata), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));

   iec_regs dut (.mclk(mclk), .reset_n(reset_n), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ev_early_tx(strobe[4]),
      .ev_early_rx(strobe[3]), .rx_first_desc_filled(rx_fill), .ev_link_change(strobe[2]),
      .ev_deferred_tx(strobe[1]), .ev_pause_rx(strobe[0]), .primary_irq_enable(prim),
      .cardbus_mode(card), .eeprom_load(strobe[7]), .eeprom_word(eword),
      .wake_event(strobe[5]), .power_up(strobe[6]), .wake_pin_o(wpo), .wake_pin_oe(wpoe),
      .config_reg_48_bit31(c48), .conventional_pad(pad), .led_four(led4),
      .rx_fifo_size(rxfs), .normal_summary_add(nsum), .abnormal_summary_add(asum), .irq(irq));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch at %0t: saw %h expected %h", $time, s, e);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] w);
      logic [31:0] v;
      host.xfer(a, 1'b1, w, v);
      // Register lands on the closing edge; let it settle before callers look
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] v;
      host.xfer(a, 1'b0, 32'h0, v);
      chk(v, e);
   endtask : rd

   // One-cycle strobe; settles before the caller looks
   task automatic pulse(input logic [7:0] v);
      @(posedge mclk);
      strobe <= v;
      @(posedge mclk);
      strobe <= 8'h0;
      #1;
   endtask : pulse

   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : results

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      rx_fill = 1'b0;
      card = 1'b1;
      repeat (3) @(posedge mclk);
      reset_n <= 1'b1;
      #1;
      chk({28'h0, irq, wpoe, c48, nsum}, 32'h0);
      rd(8'h84, 32'h00001234);
      rd(8'h88, 32'h00000000);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, rows[i].e);
      end
      wr(8'h88, 32'h8FC00000);
      chk({25'h0, c48, wpoe, pad, led4, rxfs, wpo}, 32'h7D);
      card <= 1'b0;
      pulse(8'h20);
      chk({30'h0, pad, wpo}, 32'h0);
      pulse(8'h40);
      chk({31'h0, wpo}, 32'h0);
      wr(8'h88, 32'h8EC00000);
      pulse(8'h40);
      chk({31'h0, wpo}, 32'h1);
      pulse(8'h80);
      rd(8'h88, 32'h8FE00000);
      chk({30'h0, rxfs}, 32'h3);
      // Summaries and latched status
      wr(8'h84, 32'hE0018000);
      pulse(8'h10);
      chk({30'h0, nsum, irq}, 32'h3);
      rd(8'h80, 32'h80011234);
      rd(8'h90, 32'h00000010);
      wr(8'h80, 32'h80010000);
      chk({30'h0, nsum, irq}, 32'h0);
      pulse(8'h08);
      rd(8'h80, 32'h00001234);
      rx_fill <= 1'b1;
      pulse(8'h08);
      chk({31'h0, nsum}, 32'h1);
      pulse(8'h04);
      chk({31'h0, asum}, 32'h1);
      wr(8'h80, 32'hE0018000);
      pulse(8'h03);
      chk({30'h0, asum, irq}, 32'h1);
      rd(8'h80, 32'h14001234);
      rd(8'h90, 32'h0000000F);
      wr(8'h94, 32'h0);
      pulse(8'h04);
      chk({31'h0, irq}, 32'h0);
      // Second reset in mid-run
      @(posedge mclk);
      reset_n <= 1'b0;
      #1;
      chk({20'h0, hreadyout, hresp, irq, wpoe, c48, pad, led4, rxfs, wpo, nsum, asum}, 32'h800);
      chk(hrdata, 32'h0);
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      rd(8'h84, 32'h00001234);
      rd(8'h88, 32'h00000000);
      results();
   end
endmodule : tb

`default_nettype wire
